// ==== rtl/comparator_gain_control.sv ====
`include "cmp_gain_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module comparator_gain_control
(
   input  wire logic                     clk_sys,       // System clock 125 MHz
   input  wire logic                     reset,         // Sync reset, active high
   input  wire logic                     clk_en,        // Freezes all state when low
   input  wire logic [3:0]               reg_addr,      // Register address
   input  wire logic [7:0]               reg_wdata,     // Write data
   input  wire logic                     reg_wr,        // Write strobe
   input  wire logic                     reg_rd,        // Read strobe
   output logic      [7:0]               reg_rdata,     // Read data, cycle after strobe
   input  wire logic                     cmp_above_low, // Plus input above lower ref
   input  wire logic                     cmp_below_up,  // Plus input below upper ref
   output logic                          amp_enable,    // Amplifier running
   output logic                          feedback_ground_select, // 1: amp ground pin
   output cmp_gain_pkg::gain_code_t      gain_code,     // Amplification factor
   output logic                          cmp_in_reset,  // Comparator held in reset
   output logic                          cmp_clk_on,    // Comparator clock supplied
   output cmp_gain_pkg::plus_sel_t       plus_route,    // Plus input routing
   output cmp_gain_pkg::minus_sel_t      minus_route,   // Minus input routing
   output logic                          ref_from_bandgap, // Reference from bandgap pin
   output logic                          window_mode,   // Window comparison active
   output logic                          cmp_active,    // Comparator enable bit, not gated by its clock or reset
   output logic                          edge_irq,      // One-cycle edge request
   output logic                          irq            // Level interrupt
);
   import cmp_gain_pkg::*;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0]  amp_ctl_ff;
   logic [7:0]  prst_ff;
   logic [7:0]  pclk_ff;
   logic [7:0]  insel_ff;
   logic [7:0]  mode_ff;
   logic [7:0]  filt_ff;
   logic        irq_stat_ff;
   logic        irq_mask_ff;
   logic [7:0]  rdata_ff;
   logic        result_ff;
   logic        filt_out_ff;
   logic        filt_prev_ff;
   logic        filt_cand_ff;
   filt_state_t fstate_ff;
   logic [4:0]  div_ff;
   logic        edge_ff;
   logic        irq_ff;

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire wr_amp   = clk_en && reg_wr && hit(reg_addr, `OFS_AMP_CONTROL);
   wire wr_prst  = clk_en && reg_wr && hit(reg_addr, `OFS_PRST_ONE);
   wire wr_pclk  = clk_en && reg_wr && hit(reg_addr, `OFS_PCLKEN_ONE);
   wire wr_insel = clk_en && reg_wr && hit(reg_addr, `OFS_CMP_INSEL);
   wire wr_mode  = clk_en && reg_wr && hit(reg_addr, `OFS_CMP_MODE);
   wire wr_filt  = clk_en && reg_wr && hit(reg_addr, `OFS_CMP_FILTER);
   wire wr_stat  = clk_en && reg_wr && hit(reg_addr, `OFS_IRQ_STATUS);
   wire wr_mask  = clk_en && reg_wr && hit(reg_addr, `OFS_IRQ_MASK);

   // Forbidden selection codes are dropped, field keeps old value
   wire [1:0] wr_plus  = (reg_wdata[3:2] == PLUS_BANNED) ? insel_ff[3:2] : reg_wdata[3:2];
   wire [1:0] wr_minus = (reg_wdata[1:0] == MINUS_BANNED) ? insel_ff[1:0] : reg_wdata[1:0];

   // ****************************************************************
   // Comparator core
   // ****************************************************************
   wire cmp_clk_ok  = pclk_ff[`BIT_CMP_CLK_EN];
   wire cmp_rst     = prst_ff[`BIT_CMP_RESET];
   wire cmp_run     = cmp_clk_ok && !cmp_rst && mode_ff[`BIT_CMP_ENABLE];
   wire win_on      = mode_ff[`BIT_WINDOW_SEL];
   wire raw_std     = cmp_above_low;
   wire raw_win     = cmp_above_low && cmp_below_up;
   wire raw_result  = cmp_run && (win_on ? raw_win : raw_std);

   // ****************************************************************
   // Noise filter
   // ****************************************************************
   wire [1:0] fsel      = filt_ff[1:0];
   wire       div_last  = (fsel == FILT_DIV8) ? (div_ff == `DIV_BY_8_LAST)
                                              : (div_ff == `DIV_BY_32_LAST);
   wire       tick      = (fsel == FILT_CLK) || (fsel != FILT_OFF && div_last);
   wire [4:0] nxt_div   = (fsel == FILT_OFF || div_last) ? 5'h00 : div_ff + 5'h01;
   wire       stable    = (result_ff == filt_cand_ff);
   wire       filt_edge = tick && stable && (filt_cand_ff != filt_out_ff);
   wire       nxt_filt_out = (fsel == FILT_OFF) ? result_ff
                            : (filt_edge ? filt_cand_ff : filt_out_ff);
   wire       nxt_cand  = tick ? result_ff : filt_cand_ff;

   filt_state_t nxt_fstate;
   always_comb
   begin
      case (fstate_ff)
         FS_IDLE: nxt_fstate = FS_LOW;
         FS_LOW:  nxt_fstate = nxt_filt_out ? FS_HIGH : FS_LOW;
         FS_HIGH: nxt_fstate = nxt_filt_out ? FS_HIGH : FS_LOW;
         default: nxt_fstate = FS_IDLE;
      endcase
   end

   // ****************************************************************
   // Edge detect
   // ****************************************************************
   wire rise     = filt_out_ff && !filt_prev_ff;
   wire fall     = !filt_out_ff && filt_prev_ff;
   wire pol_edge = filt_ff[`BIT_EDGE_POL] ? fall : rise;
   wire nxt_edge = (fstate_ff != FS_IDLE) &&
                   (filt_ff[`BIT_BOTH_EDGE] ? (rise || fall) : pol_edge);
   wire nxt_stat = edge_ff || (irq_stat_ff && !(wr_stat && reg_wdata[0]));
   wire nxt_irq  = nxt_stat && irq_mask_ff;

   // ****************************************************************
   // Read mux
   // ****************************************************************
   wire [7:0] mode_rd = {4'h0, result_ff, mode_ff[2:0]};
   wire [7:0] nxt_rdata =
      !reg_rd                              ? `ZERO_BYTE :
      hit(reg_addr, `OFS_AMP_CONTROL)      ? amp_ctl_ff :
      hit(reg_addr, `OFS_PRST_ONE)         ? prst_ff :
      hit(reg_addr, `OFS_PCLKEN_ONE)       ? pclk_ff :
      hit(reg_addr, `OFS_CMP_INSEL)        ? insel_ff :
      hit(reg_addr, `OFS_CMP_MODE)         ? mode_rd :
      hit(reg_addr, `OFS_CMP_FILTER)       ? filt_ff :
      hit(reg_addr, `OFS_IRQ_STATUS)       ? {7'h00, irq_stat_ff} :
      hit(reg_addr, `OFS_IRQ_MASK)         ? {7'h00, irq_mask_ff} : `ZERO_BYTE;

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         amp_ctl_ff  <= `RST_AMP_CONTROL;
         prst_ff     <= `RST_PRST_ONE;
         pclk_ff     <= `RST_PCLKEN_ONE;
         insel_ff    <= `RST_CMP_INSEL;
         mode_ff     <= `RST_CMP_MODE;
         filt_ff     <= `RST_CMP_FILTER;
         irq_mask_ff <= 1'b0;
         rdata_ff    <= `ZERO_BYTE;
      end
      else if (clk_en)
      begin
         if (wr_amp)
            amp_ctl_ff <= reg_wdata & `WMASK_AMP_CONTROL;
         if (wr_prst)
            prst_ff <= reg_wdata & `WMASK_PRST_ONE;
         if (wr_pclk)
            pclk_ff <= reg_wdata & `WMASK_PCLKEN_ONE;
         if (wr_insel && cmp_clk_ok)
            insel_ff <= {4'h0, wr_plus, wr_minus};
         if (wr_mode && cmp_clk_ok)
            mode_ff <= reg_wdata & `WMASK_CMP_MODE;
         if (wr_filt && cmp_clk_ok)
            filt_ff <= reg_wdata & `WMASK_CMP_FILTER;
         if (wr_mask)
            irq_mask_ff <= reg_wdata[0];
         rdata_ff <= nxt_rdata;
      end
   end

   // Comparator domain state, cleared by its own peripheral reset
   always_ff @(posedge clk_sys)
   begin
      if (reset || (clk_en && cmp_rst))
      begin
         result_ff    <= 1'b0;
         filt_out_ff  <= 1'b0;
         filt_prev_ff <= 1'b0;
         filt_cand_ff <= 1'b0;
         div_ff       <= 5'h00;
         fstate_ff    <= FS_IDLE;
         edge_ff      <= 1'b0;
      end
      else if (clk_en && cmp_clk_ok)
      begin
         result_ff    <= raw_result;
         filt_cand_ff <= nxt_cand;
         filt_out_ff  <= nxt_filt_out;
         filt_prev_ff <= filt_out_ff;
         div_ff       <= nxt_div;
         fstate_ff    <= nxt_fstate;
         edge_ff      <= nxt_edge;
      end
      else if (clk_en)
         edge_ff <= 1'b0;
   end

   // Status set wins over write-one clear
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         irq_stat_ff <= 1'b0;
         irq_ff      <= 1'b0;
      end
      else if (clk_en)
      begin
         irq_stat_ff <= nxt_stat;
         irq_ff      <= nxt_irq;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata              = rdata_ff;
   assign amp_enable             = amp_ctl_ff[`BIT_AMP_ENABLE];
   assign feedback_ground_select = amp_ctl_ff[`BIT_FB_GND_SEL];
   assign gain_code              = gain_code_t'(amp_ctl_ff[1:0]);
   assign cmp_in_reset           = prst_ff[`BIT_CMP_RESET];
   assign cmp_clk_on             = pclk_ff[`BIT_CMP_CLK_EN];
   assign plus_route             = plus_sel_t'(insel_ff[3:2]);
   assign minus_route            = minus_sel_t'(insel_ff[1:0]);
   assign ref_from_bandgap       = mode_ff[`BIT_REF_SRC_SEL];
   assign window_mode            = mode_ff[`BIT_WINDOW_SEL];
   assign cmp_active             = mode_ff[`BIT_CMP_ENABLE];
   assign edge_irq               = edge_ff;
   assign irq                    = irq_ff;

endmodule : comparator_gain_control

`default_nettype wire

// ==== inc/cmp_gain_defines.svh ====
`ifndef CMP_GAIN_DEFINES_SVH
`define CMP_GAIN_DEFINES_SVH

// ****************************************************************
// Register offsets (8-bit registers, one per address)
// ****************************************************************
`define OFS_AMP_CONTROL   4'h0
`define OFS_PRST_ONE      4'h1
`define OFS_PCLKEN_ONE    4'h2
`define OFS_CMP_INSEL     4'h3
`define OFS_CMP_MODE      4'h4
`define OFS_CMP_FILTER    4'h5
`define OFS_IRQ_STATUS    4'h6
`define OFS_IRQ_MASK      4'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_AMP_ENABLE    7
`define BIT_FB_GND_SEL    3
`define BIT_CMP_RESET     5
`define BIT_CMP_CLK_EN    5
`define BIT_RESULT_FLAG   3
`define BIT_REF_SRC_SEL   2
`define BIT_WINDOW_SEL    1
`define BIT_CMP_ENABLE    0
`define BIT_BOTH_EDGE     3
`define BIT_EDGE_POL      2

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define RST_AMP_CONTROL   8'h00
`define RST_PRST_ONE      8'h00
`define RST_PCLKEN_ONE    8'h00
`define RST_CMP_INSEL     8'h00
`define RST_CMP_MODE      8'h00
`define RST_CMP_FILTER    8'h00
`define RST_IRQ_MASK      8'h00
`define WMASK_AMP_CONTROL 8'h8B
`define WMASK_PRST_ONE    8'h20
`define WMASK_PCLKEN_ONE  8'h20
`define WMASK_CMP_INSEL   8'h0F
`define WMASK_CMP_MODE    8'h07
`define WMASK_CMP_FILTER  8'h0F

// ****************************************************************
// Filter sampling dividers
// ****************************************************************
`define DIV_BY_8_LAST     5'h07
`define DIV_BY_32_LAST    5'h1F
`define ZERO_BYTE         8'h00

`endif

// ==== inc/cmp_gain_pkg.sv ====
package cmp_gain_pkg;
   typedef enum logic [1:0] {
      GAIN_X4  = 2'h0,
      GAIN_X8  = 2'h1,
      GAIN_X16 = 2'h2,
      GAIN_X32 = 2'h3
   } gain_code_t;

   typedef enum logic [1:0] {
      PLUS_NONE   = 2'h0,
      PLUS_PIN    = 2'h1,
      PLUS_AMP    = 2'h2,
      PLUS_BANNED = 2'h3
   } plus_sel_t;

   typedef enum logic [1:0] {
      MINUS_NONE   = 2'h0,
      MINUS_PIN    = 2'h1,
      MINUS_DAC    = 2'h2,
      MINUS_BANNED = 2'h3
   } minus_sel_t;

   typedef enum logic [1:0] {
      FILT_OFF    = 2'h0,
      FILT_CLK    = 2'h1,
      FILT_DIV8   = 2'h2,
      FILT_DIV32  = 2'h3
   } filt_sel_t;

   typedef enum logic [2:0] {
      FS_IDLE   = 3'b001,
      FS_LOW    = 3'b010,
      FS_HIGH   = 3'b100
   } filt_state_t;
endpackage : cmp_gain_pkg

// ==== sim/cmp_gain_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmp_gain_props
(
   input wire logic                     clk_sys,   // Clock
   input wire logic                     reset,     // Sync reset
   input wire logic                     clk_en,    // State frozen when low
   input wire logic [3:0]               reg_addr,  // Address
   input wire logic [7:0]               reg_wdata, // Write data
   input wire logic                     reg_wr,    // Write strobe
   input wire logic                     amp_enable, // Amp on
   input wire logic                     feedback_ground_select, // Fb ground
   input wire cmp_gain_pkg::gain_code_t gain_code, // Gain
   input wire logic                     cmp_in_reset, // Cmp reset
   input wire logic                     cmp_clk_on, // Cmp clock
   input wire cmp_gain_pkg::plus_sel_t  plus_route, // Plus route
   input wire cmp_gain_pkg::minus_sel_t minus_route, // Minus route
   input wire logic                     ref_from_bandgap, // Bandgap ref
   input wire logic                     window_mode, // Window
   input wire logic                     cmp_active // Enabled
);
   import cmp_gain_pkg::*;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // Write to a gated comparator register while its clock runs
   sequence s_cfg_wr(a);
      reg_wr && clk_en && reg_addr == a && cmp_clk_on && !cmp_in_reset;
   endsequence
   a_amp_fields: assert property (
      reg_wr && clk_en && reg_addr == 4'h0 |=> amp_enable == $past(reg_wdata[7])
      && feedback_ground_select == $past(reg_wdata[3]) && gain_code == $past(reg_wdata[1:0]))
      else $error("amp control outputs wrong after write");
   a_cmp_reset: assert property (
      reg_wr && clk_en && reg_addr == 4'h1 |=> cmp_in_reset == $past(reg_wdata[5]))
      else $error("comparator reset output wrong");
   a_cmp_clock: assert property (
      reg_wr && clk_en && reg_addr == 4'h2 |=> cmp_clk_on == $past(reg_wdata[5]))
      else $error("comparator clock output wrong");
   a_plus_route: assert property (
      s_cfg_wr(4'h3) ##0 reg_wdata[3:2] != 2'h3 |=> plus_route == $past(reg_wdata[3:2]))
      else $error("plus route wrong");
   a_plus_banned: assert property (
      s_cfg_wr(4'h3) ##0 reg_wdata[3:2] == 2'h3 |=> $stable(plus_route))
      else $error("banned plus code taken");
   a_minus_route: assert property (
      s_cfg_wr(4'h3) ##0 reg_wdata[1:0] != 2'h3 |=> minus_route == $past(reg_wdata[1:0]))
      else $error("minus route wrong");
   a_minus_banned: assert property (
      s_cfg_wr(4'h3) ##0 reg_wdata[1:0] == 2'h3 |=> $stable(minus_route))
      else $error("banned minus code taken");
   a_mode_bits: assert property (
      s_cfg_wr(4'h4) |=> ref_from_bandgap == $past(reg_wdata[2])
      && window_mode == $past(reg_wdata[1]) && cmp_active == $past(reg_wdata[0]))
      else $error("mode outputs wrong");
endmodule : cmp_gain_props
`default_nettype wire

// ==== sim/analog_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
(
   input wire logic [7:0]               vin,  // Analog input pin level
   input wire logic [7:0]               vref, // Reference pin level
   input wire logic [7:0]               vdac, // D/A output level
   input wire logic [7:0]               vbg,  // Bandgap level
   input wire logic [7:0]               vup,  // Upper reference level
   input wire logic                     amp_enable, // Amp running
   input wire cmp_gain_pkg::gain_code_t gain_code, // Gain
   input wire cmp_gain_pkg::plus_sel_t  plus_route, // Plus route
   input wire cmp_gain_pkg::minus_sel_t minus_route, // Minus route
   input wire logic                     ref_from_bandgap, // Bandgap ref
   output logic                         above_low, // Plus above reference
   output logic                         below_up   // Plus below upper
);
   import cmp_gain_pkg::*;
   logic [15:0] amp_out;
   logic [15:0] plus_lvl;
   logic [15:0] minus_lvl;
   assign amp_out = amp_enable ? {8'h00, vin} << (gain_code + 2) : 16'h0000;
   assign plus_lvl = plus_route == PLUS_PIN ? {8'h00, vin} :
                     plus_route == PLUS_AMP ? amp_out : 16'h0000;
   // Nothing selected leaves the minus side at top, never above
   assign minus_lvl = ref_from_bandgap ? {8'h00, vbg} :
                      minus_route == MINUS_PIN ? {8'h00, vref} :
                      minus_route == MINUS_DAC ? {8'h00, vdac} : 16'hFFFF;
   assign above_low = plus_lvl > minus_lvl;
   assign below_up = plus_lvl < {8'h00, vup};
endmodule : analog_front_model
`default_nettype wire

// ==== sim/comparator_gain_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module comparator_gain_control_tb_top;
   import cmp_gain_pkg::*;
   logic       clk_sys = 1'b0;
   logic       reset = 1'b1;
   logic       clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata, d;
   logic       cmp_above_low, cmp_below_up, amp_enable, feedback_ground_select;
   logic       cmp_in_reset, cmp_clk_on, ref_from_bandgap, window_mode, cmp_active;
   logic       edge_irq, irq;
   gain_code_t gain_code;
   plus_sel_t  plus_route;
   minus_sel_t minus_route;
   logic [7:0] vin = 8'h00, vref = 8'h80, vdac = 8'h80, vbg = 8'h40, vup = 8'hE0;
   int         err_count = 0, checked = 0, pulses = 0, p0, i;
   localparam logic [19:0] ROWS [20] = '{20'h0FF8B, 20'h08080, 20'h08181, 20'h08282,
      20'h08383, 20'h00808, 20'h1FF20, 20'h10000, 20'h2FF20, 20'h30909, 20'h30F09,
      20'h30E0A, 20'h30606, 20'h5FF0F, 20'h50000, 20'h4FF07, 20'h40000, 20'h70101,
      20'h8FF00, 20'h60000};
   localparam logic [7:0] CFG [6] = '{8'h00, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B};
   localparam logic [7:0] RISE [6] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
   localparam logic [7:0] FALL [6] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (edge_irq === 1'b1) pulses <= pulses + 1;
   comparator_gain_control dut_u (.clk_sys, .reset, .clk_en, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .cmp_above_low, .cmp_below_up, .amp_enable,
      .feedback_ground_select, .gain_code, .cmp_in_reset, .cmp_clk_on, .plus_route,
      .minus_route, .ref_from_bandgap, .window_mode, .cmp_active, .edge_irq, .irq);
   analog_front_model afm_u (.vin, .vref, .vdac, .vbg, .vup, .amp_enable, .gain_code,
      .plus_route, .minus_route, .ref_from_bandgap, .above_low(cmp_above_low),
      .below_up(cmp_below_up));
   // ************************************************************
   // Bus cycles and checks
   // ************************************************************
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic final_report;
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   initial
   begin
      #800000;
      err_count++;
      final_report();
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      idle(12);
      reset <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         rd(i[3:0], d);
         chk(d, 8'h00);
      end
      for (i = 0; i < 20; i++)
      begin
         wr(ROWS[i][19:16], ROWS[i][15:8]);
         rd(ROWS[i][19:16], d);
         chk(d, ROWS[i][7:0]);
      end
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h05);
      wr(4'h2, 8'h20);
      rd(4'h3, d);
      chk(d, 8'h06);
      wr(4'h3, 8'h05);
      wr(4'h4, 8'h01);
      for (i = 0; i < 6; i++)
      begin
         wr(4'h5, CFG[i]);
         idle(100);
         p0 = pulses;
         vin <= 8'hC0;
         idle(150);
         chk(8'(pulses - p0), RISE[i]);
         p0 = pulses;
         vin <= 8'h40;
         idle(150);
         chk(8'(pulses - p0), FALL[i]);
      end
      p0 = pulses;
      vin <= 8'hC0;
      idle(3);
      vin <= 8'h40;
      idle(150);
      chk(8'(pulses - p0), 8'h00);
      rd(4'h6, d);
      chk(d, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(4'h7, 8'h00);
      idle(3);
      chk({7'h00, irq}, 8'h00);
      wr(4'h7, 8'h01);
      idle(3);
      chk({7'h00, irq}, 8'h01);
      wr(4'h6, 8'h01);
      idle(3);
      chk({7'h00, irq}, 8'h00);
      wr(4'h5, 8'h00);
      vin <= 8'hC0;
      idle(2);
      rd(4'h4, d);
      chk(d, 8'h09);
      wr(4'h4, 8'h03);
      idle(2);
      rd(4'h4, d);
      chk(d, 8'h0B);
      vin <= 8'hF0;
      idle(2);
      rd(4'h4, d);
      chk(d, 8'h03);
      wr(4'h4, 8'h05);
      idle(2);
      rd(4'h4, d);
      chk(d, 8'h0D);
      wr(4'h4, 8'h04);
      idle(2);
      rd(4'h4, d);
      chk(d, 8'h04);
      clk_en <= 1'b0;
      wr(4'h0, 8'h80);
      clk_en <= 1'b1;
      rd(4'h0, d);
      chk(d, 8'h08);
      reset <= 1'b1;
      idle(2);
      reset <= 1'b0;
      p0 = pulses;
      rd(4'h0, d);
      chk(d, 8'h00);
      @(posedge clk_sys);
      #1 chk(reg_rdata, 8'h00);
      chk(8'(pulses - p0), 8'h00);
      final_report();
   end
endmodule : comparator_gain_control_tb_top
bind comparator_gain_control cmp_gain_props chk_u (.clk_sys, .reset, .clk_en, .reg_addr,
   .reg_wdata,
   .reg_wr, .amp_enable, .feedback_ground_select, .gain_code, .cmp_in_reset, .cmp_clk_on,
   .plus_route, .minus_route, .ref_from_bandgap, .window_mode, .cmp_active);
`default_nettype wire
